/* dv/aie_regfile_model.sv */
module aie_regfile_model (
  input wire logic core_clk, // core clock
  input wire logic [6:0] file_addr, // read address
  input wire aie_pkg::aie_file_wr_t file_wr, // write port
  output logic [7:0] file_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  // combinational read, write on the pulse
  assign file_rdata = mem[file_addr];
  always @(posedge core_clk) begin
    if (file_wr.en === 1'b1) begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end
endmodule : aie_regfile_model

/* dv/alu_instruction_subset_exec_tb.sv */
module alu_instruction_subset_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [13:0] w;
    logic [7:0] acc;
    logic [2:0] fl;
    logic we;
    logic [7:0] wd;
  } aie_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata;
  logic [6:0] file_addr;
  aie_pkg::aie_file_wr_t file_wr;
  logic [7:0] acc;
  aie_pkg::aie_flags_t flags;
  logic watchdog_clear, watchdog_expiry_flag, sleep_flag, skip_busy, instr_done;
  int num_errors = 0;
  int comparisons = 0;
  aie_row_t rows [12] = '{
    '{14'h3E15, 8'h15, 3'b000, 1'b0, 8'h00},
    '{14'h3EFB, 8'h10, 3'b110, 1'b0, 8'h00}, '{14'h3900, 8'h00, 3'b111, 1'b0, 8'h00},
    '{14'h3E25, 8'h25, 3'b000, 1'b0, 8'h00}, '{14'h3FF0, 8'h15, 3'b100, 1'b0, 8'h00},
    '{14'h0720, 8'h00, 3'b111, 1'b0, 8'h00}, '{14'h09A0, 8'h00, 3'b110, 1'b1, 8'h14},
    '{14'h05A0, 8'h00, 3'b111, 1'b1, 8'h00}, '{14'h03A0, 8'h00, 3'b110, 1'b1, 8'hFF},
    '{14'h0B20, 8'hFE, 3'b110, 1'b0, 8'h00}, '{14'h07A0, 8'hFE, 3'b110, 1'b1, 8'hFD},
    '{14'h0064, 8'hFE, 3'b110, 1'b0, 8'h00}};
  aie_exec dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rdata(file_rdata), .file_addr(file_addr),
    .file_wr(file_wr), .acc(acc), .flags(flags), .watchdog_clear(watchdog_clear),
    .watchdog_expiry_flag(watchdog_expiry_flag), .sleep_flag(sleep_flag),
    .skip_busy(skip_busy), .instr_done(instr_done));
  aie_regfile_model rf (.core_clk(core_clk), .file_addr(file_addr), .file_wr(file_wr),
    .file_rdata(file_rdata));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // ******************************
  // main sequence
  // ******************************
  initial begin
    rf.mem[7'h20] = 8'hEB;
    rf.mem[7'h30] = 8'h01;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    check(acc === 8'h00 && flags === 3'b000 && instr_done === 1'b0, "reset outputs");
    check(watchdog_expiry_flag === 1'b1 && sleep_flag === 1'b1, "reset status flags");
    foreach (rows[i]) begin
      instr_word = rows[i].w;
      instr_valid = 1'b1;
      @(negedge core_clk);
      instr_valid = 1'b0;
      check(acc === rows[i].acc && flags === rows[i].fl, "acc or flags");
      check(file_wr.en === rows[i].we && instr_done === 1'b1, "write or done");
      check(!rows[i].we || (file_wr.data === rows[i].wd && file_wr.addr === 7'h20),
        "write data");
      check(watchdog_clear === (rows[i].w == 14'h0064) && skip_busy === 1'b0,
        "watchdog pulse");
      check(watchdog_expiry_flag === 1'b1 && sleep_flag === 1'b1, "status flags");
      @(negedge core_clk);
    end
    // taken skip followed at once by a word that must be dropped
    instr_word = 14'h0BB0;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_word = 14'h3E01;
    check(file_wr.en === 1'b1 && file_wr.data === 8'h00 && file_wr.addr === 7'h30,
      "skip write");
    check(skip_busy === 1'b1 && instr_done === 1'b0 && flags === 3'b110, "skip start");
    @(negedge core_clk);
    instr_valid = 1'b0;
    check(instr_done === 1'b1 && skip_busy === 1'b0 && acc === 8'hFE, "skip end");
    @(negedge core_clk);
    check(acc === 8'hFE && instr_done === 1'b0, "dropped word ran");
    // back to back: second word reads the register the first just wrote
    instr_word = 14'h0BB0;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_word = 14'h09B0;
    check(file_wr.en === 1'b1 && file_wr.data === 8'hFF && skip_busy === 1'b0
      && flags === 3'b110, "skip not taken");
    @(negedge core_clk);
    instr_word = 14'h0064;
    check(file_wr.en === 1'b1 && file_wr.data === 8'h00 && flags === 3'b111
      && instr_done === 1'b1, "forwarded read");
    @(negedge core_clk);
    check(watchdog_clear === 1'b1 && file_wr.en === 1'b0, "first clear");
    @(negedge core_clk);
    instr_valid = 1'b0;
    check(watchdog_clear === 1'b1 && instr_done === 1'b1, "second clear");
    @(negedge core_clk);
    check(watchdog_clear === 1'b0 && instr_done === 1'b0, "clear pulse ended");
    // reset in mid-run, then a word at the first edge after release
    rst = 1'b1;
    @(negedge core_clk);
    check(acc === 8'h00 && flags === 3'b000 && file_wr.en === 1'b0
      && watchdog_expiry_flag === 1'b1 && sleep_flag === 1'b1, "mid-run reset");
    rst = 1'b0;
    instr_word = 14'h3E15;
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
    check(acc === 8'h15 && instr_done === 1'b1 && flags === 3'b000,
      "first word after reset");
    tally_and_finish();
  end
  initial begin
    #2000;
    num_errors++;
    tally_and_finish();
  end
endmodule : alu_instruction_subset_exec_tb

/* shared/aie_defines.svh */
`ifndef AIE_DEFINES_SVH
`define AIE_DEFINES_SVH
// opcode patterns, top six bits of the 14-bit word; the watchdog clear word is all 14 bits
`define AIE_OPC_ADD_LIT 6'h3E
`define AIE_OPC_ADD_LIT_MASK 6'h3E
`define AIE_OPC_AND_LIT 6'h39
`define AIE_OPC_ADD_FILE 6'h07
`define AIE_OPC_AND_FILE 6'h05
`define AIE_OPC_INV_FILE 6'h09
`define AIE_OPC_DEC_FILE 6'h03
`define AIE_OPC_DEC_SKIP 6'h0B
`define AIE_WORD_CLR_WDOG 14'h0064
`define AIE_DEST_BIT 7
`define AIE_ACC_RST 8'h00
`define AIE_WDOG_CLEAR 8'h00
`endif

/* shared/aie_pkg.sv */
package aie_pkg;
  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } aie_flags_t;
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } aie_file_wr_t;
  typedef enum logic [0:0] {
    AIE_EXEC = 1'b0,
    AIE_FLUSH = 1'b1
  } aie_state_t;
endpackage : aie_pkg

/* verilog/aie_exec.sv */
`include "aie_defines.svh"
// Overview of operation
// - literal add: acc plus literal into acc, carry, half-carry, zero updated.
// - literal and: acc and literal into acc, only zero updated.
// - file add: acc plus file register, carry, half-carry, zero updated.
// - file and: acc and file register, only zero updated.
// - destination bit 0 writes acc, 1 writes the file register back.
// - invert file register, route by destination bit, only zero updated.
// - decrement file register, route by destination, zero set when result zero.
// - decrement-and-skip routes result by destination, flags untouched.
// - skip on zero result discards fetched word, runs a no-op cycle.
// - watchdog clear word zeroes the watchdog counter and its prescaler.
// - watchdog clear sets watchdog-expiry and sleep flags to one.
// - every instruction here is one word, one cycle, except a taken skip.
module aie_exec (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic instr_valid, // fetched word valid this cycle
  input wire logic [13:0] instr_word, // fetched instruction word
  input wire logic [7:0] file_rdata, // addressed register value
  output logic [6:0] file_addr, // register address of current word
  output aie_pkg::aie_file_wr_t file_wr, // file register write
  output logic [7:0] acc, // accumulator
  output aie_pkg::aie_flags_t flags, // carry, half-carry, zero
  output logic watchdog_clear, // pulse: clear watchdog_counter and prescaler
  output logic watchdog_expiry_flag, // set by clear_watchdog_op
  output logic sleep_flag, // set by clear_watchdog_op
  output logic skip_busy, // high during discarded cycle
  output logic instr_done // pulse: instruction retired
);
  // ****************************************
  // decode
  // ****************************************
  logic [5:0] opc;
  logic [7:0] lit;
  logic dest_file;
  logic add_literal_to_acc_op;
  logic and_literal_op;
  logic add_file_op;
  logic and_acc_with_file_op;
  logic invert_file_op;
  logic dec_file_op;
  logic decrement_skip_zero_op;
  logic clear_watchdog_op;
  assign opc = instr_word[13:8];
  assign lit = instr_word[7:0];
  assign dest_file = instr_word[`AIE_DEST_BIT];
  assign file_addr = instr_word[6:0];
  assign add_literal_to_acc_op = (opc & `AIE_OPC_ADD_LIT_MASK) == `AIE_OPC_ADD_LIT;
  assign and_literal_op = opc == `AIE_OPC_AND_LIT;
  assign add_file_op = opc == `AIE_OPC_ADD_FILE;
  assign and_acc_with_file_op = opc == `AIE_OPC_AND_FILE;
  assign invert_file_op = opc == `AIE_OPC_INV_FILE;
  assign dec_file_op = opc == `AIE_OPC_DEC_FILE;
  assign decrement_skip_zero_op = opc == `AIE_OPC_DEC_SKIP;
  assign clear_watchdog_op = instr_word == `AIE_WORD_CLR_WDOG;

  // ****************************************
  // execute
  // ****************************************
  aie_pkg::aie_state_t state_ff, nxt_state;
  logic [7:0] acc_ff, nxt_acc;
  aie_pkg::aie_flags_t flags_ff, nxt_flags;
  aie_pkg::aie_file_wr_t wr_ff, nxt_wr;
  logic wdc_ff, nxt_wdc;
  logic wexp_ff, nxt_wexp;
  logic slp_ff, nxt_slp;
  logic done_ff, nxt_done;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] opnd;
  logic [7:0] file_val;
  logic [7:0] res;
  logic route;
  logic go;

  always_comb begin
    go = instr_valid && (state_ff == aie_pkg::AIE_EXEC);
    // forward pending write
    // write lands one edge late; a back-to-back word must see it
    file_val = (wr_ff.en && (wr_ff.addr == file_addr)) ? wr_ff.data : file_rdata;
    opnd = (add_literal_to_acc_op || and_literal_op) ? lit : file_val;
    sum = {1'b0, acc_ff} + {1'b0, opnd};
    low_sum = {1'b0, acc_ff[3:0]} + {1'b0, opnd[3:0]};
    nxt_state = aie_pkg::AIE_EXEC;
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_wr = '0;
    nxt_wdc = 1'b0;
    nxt_wexp = wexp_ff;
    nxt_slp = slp_ff;
    nxt_done = 1'b0;
    res = 8'h00;
    route = 1'b0;
    unique case (state_ff)
      aie_pkg::AIE_FLUSH: begin
        nxt_done = 1'b1;
      end
      aie_pkg::AIE_EXEC: begin
        if (go) begin
          nxt_done = 1'b1;
          if (add_literal_to_acc_op || add_file_op) begin
            res = sum[7:0];
            nxt_flags.carry = sum[8];
            nxt_flags.half_carry = low_sum[4];
            nxt_flags.zero = res == 8'h00;
            route = add_file_op;
          end else if (and_literal_op || and_acc_with_file_op) begin
            res = acc_ff & opnd;
            nxt_flags.zero = res == 8'h00;
            route = and_acc_with_file_op;
          end else if (invert_file_op) begin
            res = ~file_val;
            nxt_flags.zero = res == 8'h00;
            route = 1'b1;
          end else if (dec_file_op) begin
            res = file_val - 8'h01;
            nxt_flags.zero = res == 8'h00;
            route = 1'b1;
          end else if (decrement_skip_zero_op) begin
            res = file_val - 8'h01;
            route = 1'b1;
            if (res == 8'h00) begin
              nxt_state = aie_pkg::AIE_FLUSH;
              nxt_done = 1'b0;
            end
          end else if (clear_watchdog_op) begin
            nxt_wdc = 1'b1;
            nxt_wexp = 1'b1;
            nxt_slp = 1'b1;
          end
          if (route && dest_file) begin
            nxt_wr = '{en: 1'b1, addr: file_addr, data: res};
          end else if (route || add_literal_to_acc_op || and_literal_op) begin
            nxt_acc = res;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= aie_pkg::AIE_EXEC;
      acc_ff <= `AIE_ACC_RST;
      flags_ff <= '0;
      wr_ff <= '0;
      wdc_ff <= 1'b0;
      wexp_ff <= 1'b1;
      slp_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      wr_ff <= nxt_wr;
      wdc_ff <= nxt_wdc;
      wexp_ff <= nxt_wexp;
      slp_ff <= nxt_slp;
      done_ff <= nxt_done;
    end
  end

  assign acc = acc_ff;
  assign flags = flags_ff;
  assign file_wr = wr_ff;
  assign watchdog_clear = wdc_ff;
  assign watchdog_expiry_flag = wexp_ff;
  assign sleep_flag = slp_ff;
  assign skip_busy = state_ff == aie_pkg::AIE_FLUSH;
  assign instr_done = done_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_lit_add_result: assert property (
    go && add_literal_to_acc_op |=> acc == $past(acc_ff + lit)
  ) else $error("literal add result wrong");
  a_lit_and_flags: assert property (
    go && and_literal_op |=> flags.carry == $past(flags_ff.carry)
      && flags.zero == (acc == 8'h00)
  ) else $error("literal and flags wrong");
  a_file_add_carry: assert property (
    go && add_file_op |=> flags.carry == $past(sum[8])
  ) else $error("file add carry wrong");
  a_file_and_zero: assert property (
    go && and_acc_with_file_op && !dest_file |=> flags.zero == (acc == 8'h00)
  ) else $error("file and zero wrong");
  a_dest_route: assert property (
    go && (invert_file_op || dec_file_op) && dest_file |=> file_wr.en && $stable(acc)
  ) else $error("file destination not written");
  a_invert_value: assert property (
    go && invert_file_op && !dest_file |=> acc == ~$past(file_val)
  ) else $error("complement wrong");
  a_dec_zero_flag: assert property (
    go && dec_file_op && file_val == 8'h01 |=> flags.zero
  ) else $error("decrement zero flag wrong");
  a_skip_flags_kept: assert property (
    go && decrement_skip_zero_op |=> $stable(flags)
  ) else $error("skip changed flags");
  a_skip_two_cycles: assert property (
    go && decrement_skip_zero_op && file_val == 8'h01 |=> skip_busy && !instr_done
      ##1 instr_done && !skip_busy
  ) else $error("taken skip not two cycles");
  a_wdog_clear: assert property (
    go && clear_watchdog_op |=> watchdog_clear
  ) else $error("watchdog clear pulse missing");
  a_wdog_pulse_only: assert property (
    !(go && clear_watchdog_op) |=> !watchdog_clear
  ) else $error("watchdog clear pulse without its word");
  a_wdog_flags: assert property (
    go && clear_watchdog_op |=> watchdog_expiry_flag && sleep_flag
  ) else $error("status flags not set");
  a_single_cycle: assert property (
    go && !decrement_skip_zero_op |=> instr_done
  ) else $error("instruction not single cycle");
  a_half_carry: assert property (
    go && add_literal_to_acc_op |=> flags.half_carry == $past(low_sum[4])
  ) else $error("half carry wrong");

  c_skip_taken: cover property (go && decrement_skip_zero_op ##1 skip_busy);
  c_file_write: cover property (file_wr.en);
  c_add_carry: cover property (go && add_file_op ##1 flags.carry);
  c_wdog: cover property (watchdog_clear);
endmodule : aie_exec
